// >>> design/quick_dma_event_latch.sv
// quick-dma event latching, enables, arbitration and register slave
//
// Overview of operation
// - trigger word write sets pending bit
// - link update to mapped address sets pending
// - events latch only on enabled channels
// - set beats hardware clear same cycle
// - event on pending channel sets missed bit
// - event on clear channel pends, queues
// - pending clears on request submission or on a secondary clear
// - pending bits arbitrated for request submission
// - pending register read-only, bits 7-0, rest zero
// - enable register changes only through set/clear
// - enable-clear write-one clears enable, write-only
// - enable-set write-one sets enable, write-only
// - all four registers zero after reset
// - secondary clear clears secondary and pending
`timescale 1ns/100ps
module quick_dma_event_latch #(
  parameter int unsigned CH = qdl_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       resetn_in,
  // avalon-mm slave
  input  wire logic [qdl_pkg::BUS_AW-1:0] avs_address_in,
  input  wire logic                       avs_read_in,
  input  wire logic                       avs_write_in,
  input  wire logic [31:0]                avs_writedata_in,
  input  wire logic [3:0]                 avs_byteenable_in,
  output logic      [31:0]                avs_readdata_out,
  output logic                            avs_waitrequest_out,
  // parameter-memory writes from bus masters and from link updates
  input  wire qdl_pkg::pmem_write_t       host_pwrite_in,
  input  wire qdl_pkg::pmem_write_t       link_pwrite_in,
  // transfer request toward the transfer controller
  output qdl_pkg::xfer_req_t              xfer_req_out,
  input  wire logic                       xfer_ack_in,
  // interrupt
  output logic                            irq_out
);

  // per-channel trigger mapping (word address of the trigger word)
  logic [qdl_pkg::PADDR_W-1:0] map_r [CH];
  // channel state registers
  logic [CH-1:0]               pending_r;   // pending events
  logic [CH-1:0]               enable_r;    // channel enables
  logic [CH-1:0]               missed_r;    // lost events
  logic [CH-1:0]               secondary_r; // events sitting in the queue
  logic [qdl_pkg::IRQ_W-1:0]   irq_stat_r;  // sticky interrupt causes
  logic [qdl_pkg::IRQ_W-1:0]   irq_mask_r;  // interrupt mask
  // bus slave state
  qdl_pkg::bus_state_t         bus_state_r;
  // request launch bookkeeping
  logic [2:0]                  rr_ptr_r;    // round-robin start point
  // derived strobes
  logic [CH-1:0]               event_hit;   // enabled channel events this cycle
  logic [CH-1:0]               sub_clr;     // hardware clear on submission
  logic [CH-1:0]               wr_en_clr;   // software enable clear bits
  logic [CH-1:0]               wr_en_set;   // software enable set bits
  logic [CH-1:0]               wr_miss_clr; // software missed clear bits
  logic [CH-1:0]               wr_sec_clr;  // software secondary clear bits
  logic [CH-1:0]               ready_ch;    // pending and not yet queued
  logic                        wr_take;     // write accepted this cycle
  logic [CH-1:0]               lost_ev;     // events that hit a still-pending channel
  logic [7:0]                  byte_addr;   // byte address of the request
  logic                        grant_vld;   // arbiter found a channel
  logic [2:0]                  grant_ch;    // arbiter winner

  // low channel bits of a write, gated by byte lane 0
  function automatic logic [CH-1:0] lane0_bits(input logic [31:0] d, input logic [3:0] be);
    lane0_bits = be[0] ? d[CH-1:0] : '0;
  endfunction

  // widen channel bits to a bus word, upper bits read zero
  function automatic logic [31:0] ch_word(input logic [CH-1:0] v);
    ch_word = {{(32-CH){1'b0}}, v};
  endfunction

  // byte address falls in the block of eight channel mappings
  function automatic logic is_map(input logic [7:0] a);
    is_map = (a[7:5] == qdl_pkg::OFF_MAP_BASE[7:5]);
  endfunction

  // write-one clear of one interrupt status bit by the current write
  function automatic logic stat_w1c(input logic take, input logic [7:0] a, input logic [3:0] be,
                                    input logic [31:0] d, input int unsigned pos);
    stat_w1c = take && (a == qdl_pkg::OFF_IRQ_STAT) && be[0] && d[pos];
  endfunction

  // bus decode: a request is answered one cycle after it is seen
  // only the low six word-address bits are decoded, so the map repeats
  // every 256 bytes; software keeps the upper address bits at zero
  assign byte_addr = {avs_address_in[qdl_pkg::BUS_AW-3:0], 2'b00};
  // writes act only in the answer cycle, when the master sees waitrequest
  // low; acting on the first sight of the request could apply it twice
  assign wr_take   = (bus_state_r == qdl_pkg::BUS_ACK) && avs_write_in;

  // write-one strobes per register
  always_comb begin
    wr_en_clr   = '0;
    wr_en_set   = '0;
    wr_miss_clr = '0;
    wr_sec_clr  = '0;
    if (wr_take) begin
      case (byte_addr)
        qdl_pkg::OFF_EN_CLEAR:  wr_en_clr   = lane0_bits(avs_writedata_in, avs_byteenable_in);
        qdl_pkg::OFF_EN_SET:    wr_en_set   = lane0_bits(avs_writedata_in, avs_byteenable_in);
        qdl_pkg::OFF_MISSED:    wr_miss_clr = lane0_bits(avs_writedata_in, avs_byteenable_in);
        qdl_pkg::OFF_SEC_CLEAR: wr_sec_clr  = lane0_bits(avs_writedata_in, avs_byteenable_in);
        default: begin
          // other addresses carry no write-one strobes
        end
      endcase
    end
  end

  // channel event detection against the mapping of each channel
  // host and link writes to one channel in one cycle count as a single
  // event, never as one event plus one lost event
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      event_hit[i] = enable_r[i] &&
                     ((host_pwrite_in.valid && host_pwrite_in.addr == map_r[i]) ||
                      (link_pwrite_in.valid && link_pwrite_in.addr == map_r[i]));
    end
  end

  // channels waiting for submission: pending but not yet queued
  // a queued channel is not offered again until its submission or a
  // software secondary clear drops its queued bit
  assign ready_ch = pending_r & ~secondary_r;

  // round-robin arbiter over ready channels
  // a fixed-priority scan would let a busy low channel starve the rest;
  // the start point moves past each winner so every channel gets a turn
  always_comb begin
    logic [2:0] idx;
    idx       = 3'h0;
    grant_vld = 1'b0;
    grant_ch  = 3'h0;
    for (int k = 0; k < CH; k++) begin
      idx = 3'(rr_ptr_r + 3'(k));
      if (!grant_vld && ready_ch[idx]) begin
        grant_vld = 1'b1;
        grant_ch  = idx;
      end
    end
  end

  // hardware clear when the offered request is accepted
  always_comb begin
    sub_clr = '0;
    if (xfer_req_out.valid && xfer_ack_in) begin
      sub_clr[xfer_req_out.channel] = 1'b1;
    end
  end

  // an event that finds its channel still pending is lost; when the clear
  // lands in the same cycle the new event simply re-arms the channel, but only for the hardware clear on submission
  assign lost_ev = event_hit & pending_r & ~sub_clr;

  // pending-event register
  // limitation: a secondary clear drops the pending bit but not an offer
  // already standing on the request port; that offer still completes
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_r <= qdl_pkg::RST_CH_BITS;
    end else begin
      pending_r <= (pending_r & ~sub_clr & ~wr_sec_clr) | event_hit;
    end
  end

  // enable register, reachable only via set and clear strobes
  // separate set and clear words let two tasks change different channels
  // without a read-modify-write race between them
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_r <= qdl_pkg::RST_CH_BITS;
    end else begin
      // write-one set
      // set taken last so a word writing both wins toward enable
      enable_r <= (enable_r & ~wr_en_clr) | wr_en_set;
    end
  end

  // missed-event register, sticky until software writes one
  // one bit per channel records only that some event was lost, not how
  // many were lost
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      missed_r <= qdl_pkg::RST_CH_BITS;
    end else begin
      missed_r <= (missed_r & ~wr_miss_clr) | lost_ev;
    end
  end

  // secondary register: set when the channel is queued, cleared on submission
  // it marks a channel already handed over, so a second event is kept as
  // pending or missed instead of being queued twice
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      secondary_r <= qdl_pkg::RST_CH_BITS;
    end else begin
      secondary_r <= (secondary_r & ~sub_clr & ~wr_sec_clr) |
                     ((grant_vld && !xfer_req_out.valid) ? CH'(1) << grant_ch : '0);
    end
  end

  // transfer request output: offered until acknowledged
  // only one request stands at a time; the next winner launches on the
  // edge after the acknowledge, at the cost of one idle cycle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xfer_req_out <= '0;
      rr_ptr_r     <= 3'h0;
    end else if (xfer_req_out.valid) begin
      // hold the request stable until the controller takes it
      if (xfer_ack_in) begin
        xfer_req_out.valid <= 1'b0;
      end
    end else if (grant_vld) begin
      xfer_req_out.valid   <= 1'b1;
      xfer_req_out.channel <= grant_ch;
      xfer_req_out.entry   <= map_r[grant_ch];
      rr_ptr_r             <= 3'(grant_ch + 3'h1);
    end
  end

  // trigger mapping registers, written by software
  // two channels mapped to one word both latch on a write to that word
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < CH; i++) begin
        map_r[i] <= '0;
      end
    end else if (wr_take && is_map(byte_addr)
                 && avs_byteenable_in[1:0] == 2'b11) begin
      // only full low halfword writes update a mapping
      map_r[byte_addr[4:2]] <= avs_writedata_in[qdl_pkg::PADDR_W-1:0];
    end
  end

  // interrupt status and mask
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      // a fresh event wins over a write-one clear in the same cycle
      irq_stat_r[qdl_pkg::IRQ_MISS_BIT] <=
        (irq_stat_r[qdl_pkg::IRQ_MISS_BIT] &&
         !stat_w1c(wr_take, byte_addr, avs_byteenable_in, avs_writedata_in, qdl_pkg::IRQ_MISS_BIT)) ||
        |lost_ev;
      irq_stat_r[qdl_pkg::IRQ_SUBM_BIT] <=
        (irq_stat_r[qdl_pkg::IRQ_SUBM_BIT] &&
         !stat_w1c(wr_take, byte_addr, avs_byteenable_in, avs_writedata_in, qdl_pkg::IRQ_SUBM_BIT)) ||
        (xfer_req_out.valid && xfer_ack_in);
      if (wr_take && byte_addr == qdl_pkg::OFF_IRQ_MASK && avs_byteenable_in[0]) begin
        irq_mask_r <= avs_writedata_in[qdl_pkg::IRQ_W-1:0];
      end
    end
  end

  // interrupt output registered from status and mask
  // the pin comes from a flip-flop and so trails the status by one cycle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

  // bus handshake: waitrequest high until the answer cycle
  // exactly one wait cycle per access keeps the slave simple; back to
  // back accesses therefore run at one word every two cycles
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_state_r         <= qdl_pkg::BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
    end else begin
      case (bus_state_r)
        qdl_pkg::BUS_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            bus_state_r         <= qdl_pkg::BUS_ACK;
            avs_waitrequest_out <= 1'b0;
          end
        end
        qdl_pkg::BUS_ACK: begin
          // request taken this edge; back to idle for the next one
          bus_state_r         <= qdl_pkg::BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          bus_state_r         <= qdl_pkg::BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // read data, loaded one cycle ahead so it stands with waitrequest low
  // the value is captured when the request is first seen, so a read shows
  // the state of the cycle before the answer
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= qdl_pkg::RST_WORD;
    end else if (bus_state_r == qdl_pkg::BUS_IDLE && avs_read_in) begin
      case (byte_addr)
        qdl_pkg::OFF_PENDING:   avs_readdata_out <= ch_word(pending_r);
        qdl_pkg::OFF_ENABLE:    avs_readdata_out <= ch_word(enable_r);
        qdl_pkg::OFF_MISSED:    avs_readdata_out <= ch_word(missed_r);
        qdl_pkg::OFF_SECONDARY: avs_readdata_out <= ch_word(secondary_r);
        qdl_pkg::OFF_IRQ_STAT:  avs_readdata_out <= {{(32-qdl_pkg::IRQ_W){1'b0}}, irq_stat_r};
        qdl_pkg::OFF_IRQ_MASK:  avs_readdata_out <= {{(32-qdl_pkg::IRQ_W){1'b0}}, irq_mask_r};
        // write-only registers read zero
        default: begin
          if (is_map(byte_addr)) begin
            avs_readdata_out <= {{(32-qdl_pkg::PADDR_W){1'b0}}, map_r[byte_addr[4:2]]};
          end else begin
            avs_readdata_out <= qdl_pkg::UNMAPPED_RD;
          end
        end
      endcase
    end
  end

endmodule

// >>> include/qdl_pkg.sv
// package: register map, field layouts and types for the quick-dma event latch
package qdl_pkg;
  // number of quick-dma channels
  localparam int unsigned NUM_CH = 8;
  // parameter-memory word address width
  localparam int unsigned PADDR_W = 14;
  // avalon word address width
  localparam int unsigned BUS_AW = 8;

  // register byte offsets (all chosen, none printed)
  localparam logic [7:0] OFF_PENDING   = 8'h00; // read-only pending events
  localparam logic [7:0] OFF_ENABLE    = 8'h04; // read-only channel enables
  localparam logic [7:0] OFF_EN_CLEAR  = 8'h08; // write-one enable clear
  localparam logic [7:0] OFF_EN_SET    = 8'h0c; // write-one enable set
  localparam logic [7:0] OFF_MISSED    = 8'h10; // missed events, write one to clear
  localparam logic [7:0] OFF_SECONDARY = 8'h14; // secondary (queued) events, read-only
  localparam logic [7:0] OFF_SEC_CLEAR = 8'h18; // write-one clears secondary and pending
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h1c; // sticky interrupt status, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h20; // interrupt mask
  localparam logic [7:0] OFF_MAP_BASE  = 8'h40; // eight trigger mappings, one word each

  // reset values
  localparam logic [7:0]  RST_CH_BITS = 8'h00;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  // read data returned for an unmapped address
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // interrupt status layout: bit 0 missed event, bit 1 request submitted
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_MISS_BIT = 0;
  localparam int unsigned IRQ_SUBM_BIT = 1;

  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00, // waiting for a request
    BUS_ACK  = 2'b01  // answering with waitrequest low
  } bus_state_t;

  // parameter-memory write observed by the block
  typedef struct packed {
    logic               valid; // one-cycle write strobe
    logic [PADDR_W-1:0] addr;  // word address written
  } pmem_write_t;

  // transfer request handed to the transfer controller
  typedef struct packed {
    logic               valid;   // request offered
    logic [2:0]         channel; // channel that raised it
    logic [PADDR_W-1:0] entry;   // parameter-memory entry of the channel
  } xfer_req_t;
endpackage

// >>> tb/quick_dma_event_latch_assertions.sv
// checker: port-level assertions for the quick-dma event latch
`timescale 1ns/100ps
module quick_dma_event_latch_assertions (
  // clock and reset
  input wire logic                       core_clk_in,
  input wire logic                       resetn_in,
  // register bus
  input wire logic [qdl_pkg::BUS_AW-1:0] avs_address_in,
  input wire logic                       avs_read_in,
  input wire logic                       avs_write_in,
  input wire logic [31:0]                avs_readdata_out,
  input wire logic                       avs_waitrequest_out,
  // request side and interrupt
  input wire qdl_pkg::xfer_req_t         xfer_req_out,
  input wire logic                       xfer_ack_in,
  input wire logic                       irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // read answered at this edge, per register
  wire logic done = avs_read_in && !avs_waitrequest_out;
  wire logic rd_pend = done && avs_address_in == {2'h0, qdl_pkg::OFF_PENDING[7:2]};
  wire logic rd_en = done && avs_address_in == {2'h0, qdl_pkg::OFF_ENABLE[7:2]};
  wire logic rd_clr = done && avs_address_in == {2'h0, qdl_pkg::OFF_EN_CLEAR[7:2]};
  wire logic rd_set = done && avs_address_in == {2'h0, qdl_pkg::OFF_EN_SET[7:2]};
  // bus writes are excluded, although a secondary clear leaves the offer standing
  AST_REQ_HELD: assert property (
    xfer_req_out.valid && !xfer_ack_in && !avs_write_in |=> xfer_req_out.valid && $stable(xfer_req_out.channel))
    else $error("request dropped before it was taken");
  AST_ONE_OUT: assert property (xfer_req_out.valid && xfer_ack_in |=> !xfer_req_out.valid)
    else $error("request still offered after acknowledge");
  AST_RST_IDLE: assert property ($rose(resetn_in) |-> avs_waitrequest_out && !xfer_req_out.valid && !irq_out)
    else $error("outputs not idle after reset");
  AST_PEND_RSVD: assert property (rd_pend |-> avs_readdata_out[31:8] == 24'h0)
    else $error("pending reserved bits not zero");
  AST_EN_RSVD: assert property (rd_en |-> avs_readdata_out[31:8] == 24'h0)
    else $error("enable reserved bits not zero");
  AST_CLR_WO: assert property (rd_clr |-> avs_readdata_out == 32'h0)
    else $error("enable clear reads nonzero");
  AST_SET_WO: assert property (rd_set |-> avs_readdata_out == 32'h0)
    else $error("enable set reads nonzero");
  AST_ONE_WAIT: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus access not answered after one wait");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
endmodule

// >>> tb/xfer_ctrl_model.sv
// far-side model: transfer controller taking submitted requests
`timescale 1ns/100ps
module xfer_ctrl_model (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  // request side
  input  wire qdl_pkg::xfer_req_t req_in,
  output logic                    ack_out,
  // pacing: hold stalls, delay slows
  input  wire logic               hold_in,
  input  wire logic [3:0]         delay_in
);
  logic [3:0] wait_r; // cycles the offer has waited
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_r  <= 4'h0;
      ack_out <= 1'b0;
    end else if (ack_out && req_in.valid) begin
      wait_r  <= 4'h0;
      ack_out <= 1'b0;
    end else if (req_in.valid && !hold_in) begin
      if (wait_r >= delay_in) ack_out <= 1'b1;
      else wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// >>> tb/test_quick_dma_event_latch.sv
// testbench: register table loop, then event, interrupt and reset cases
`timescale 1ns/100ps
module test_quick_dma_event_latch;
  typedef struct {bit w; logic [7:0] off; logic [31:0] d;} row_t; // write flag, offset, data or expected
  localparam logic [7:0] P_PEND = qdl_pkg::OFF_PENDING, P_EN = qdl_pkg::OFF_ENABLE, P_CLR = qdl_pkg::OFF_EN_CLEAR;
  localparam logic [7:0] P_SET = qdl_pkg::OFF_EN_SET, P_MISS = qdl_pkg::OFF_MISSED, P_SEC = qdl_pkg::OFF_SECONDARY;
  localparam logic [7:0] P_SECC = qdl_pkg::OFF_SEC_CLEAR, P_IST = qdl_pkg::OFF_IRQ_STAT;
  localparam logic [7:0] P_IMSK = qdl_pkg::OFF_IRQ_MASK, P_MAP = qdl_pkg::OFF_MAP_BASE;
  logic                 clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, hold = 1'b1; // hold stalls far end
  logic [7:0]           addr = 8'h0;
  logic [31:0]          wdata = 32'h0, rdata, q;
  logic                 wreq, ack, irq;
  logic [3:0]           dly = 4'h3;  // slow far end first
  logic [3:0]           be = 4'hf;   // byte lanes of the bus
  qdl_pkg::pmem_write_t hw = '0, lw = '0; // host and link writes
  qdl_pkg::xfer_req_t   req;
  logic [2:0]           got [$];     // channels taken, in order
  int                   n_errors = 0, n_compared = 0;
  row_t rows [20] = '{'{1'h0, P_PEND, 32'h0}, '{1'h0, P_EN, 32'h0}, '{1'h0, P_CLR, 32'h0}, '{1'h0, P_SET, 32'h0},
    '{1'h0, P_MISS, 32'h0}, '{1'h1, P_SET, 32'ha5}, '{1'h1, P_EN, 32'hff}, '{1'h0, P_EN, 32'ha5},
    '{1'h1, P_CLR, 32'h21}, '{1'h1, P_CLR, 32'h0}, '{1'h1, P_SET, 32'h0}, '{1'h0, P_EN, 32'h84},
    '{1'h1, P_PEND, 32'hff}, '{1'h0, P_PEND, 32'h0}, '{1'h1, P_SET, 32'hffff_ffff}, '{1'h0, P_EN, 32'hff},
    '{1'h0, P_PEND, 32'h0}, '{1'h0, 8'h3c, 32'h0}, '{1'h1, P_IMSK, 32'h3}, '{1'h0, P_IMSK, 32'h3}};
  quick_dma_event_latch uut (.core_clk_in(clk), .resetn_in(resetn), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .host_pwrite_in(hw), .link_pwrite_in(lw), .xfer_req_out(req),
    .xfer_ack_in(ack), .irq_out(irq));
  xfer_ctrl_model far_end (.clk_in(clk), .resetn_in(resetn), .req_in(req), .ack_out(ack), .hold_in(hold),
    .delay_in(dly));
  always #5 clk = ~clk;
  // log each request at the edge it is taken
  always @(posedge clk) begin
    if (req.valid === 1'b1 && ack === 1'b1) begin
      got.push_back(req.channel);
      chk({18'h0, req.entry}, 32'h100 + 32'(req.channel));
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // one avalon access: hold until waitrequest low, then release
  task automatic bus(input bit w, input logic [7:0] off, input logic [31:0] d, output logic [31:0] v);
    addr <= {2'h0, off[7:2]};
    wdata <= d;
    rd <= !w;
    wr <= w;
    // no limit here: a hang is ended by the watchdog
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] off, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, off, 32'h0, v);
    chk(v, e);
  endtask
  // one-cycle parameter-memory write pulse
  task automatic ev(input bit link, input logic [13:0] a);
    if (link) lw <= '{1'b1, a};
    else hw <= '{1'b1, a};
    @(posedge clk);
    hw <= '0;
    lw <= '0;
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    $display("wrong value at %0t: watchdog expired", $time);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      bus(rows[i].w, rows[i].off, rows[i].d, q);
      if (!rows[i].w) chk(q, rows[i].d);
    end
    $display("register table done");
    for (int i = 0; i < 8; i++) bus(1'b1, P_MAP + 8'(4 * i), 32'h100 + 32'(i), q);
    rd_chk(P_MAP + 8'h08, 32'h102);
    ev(1'b0, 14'h102);
    rd_chk(P_PEND, 32'h04);
    ev(1'b1, 14'h105);
    rd_chk(P_PEND, 32'h24);
    ev(1'b0, 14'h102);
    rd_chk(P_MISS, 32'h04);
    rd_chk(P_PEND, 32'h24);
    chk(32'(irq), 32'h1);
    hold <= 1'b0;
    for (int n = 0; n < 60 && got.size() < 2; n++) @(posedge clk);
    chk(32'(got.size()), 32'h2);
    chk({29'h0, got[0]}, 32'h2);
    chk({29'h0, got[1]}, 32'h5);
    rd_chk(P_PEND, 32'h0);
    rd_chk(P_MISS, 32'h04);
    bus(1'b1, P_MISS, 32'h04, q);
    rd_chk(P_MISS, 32'h0);
    rd_chk(P_IST, 32'h3);
    bus(1'b1, P_IST, 32'h3, q);
    bus(1'b1, P_IMSK, 32'h0, q);
    dly <= 4'h0;
    ev(1'b0, 14'h101);
    repeat (8) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd_chk(P_IST, 32'h2);
    bus(1'b1, P_IMSK, 32'h2, q);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(1'b1, P_IST, 32'h2, q);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    $display("event and interrupt test done");
    bus(1'b1, P_CLR, 32'h08, q);
    ev(1'b0, 14'h103);
    repeat (6) @(posedge clk);
    rd_chk(P_PEND, 32'h0);
    chk(32'(got.size()), 32'h3);
    // a set word without lane 0 leaves every enable alone
    be <= 4'he;
    bus(1'b1, P_SET, 32'h08, q);
    be <= 4'hf;
    rd_chk(P_EN, 32'hf7);
    // new event lands on the edge that takes the request
    ev(1'b0, 14'h104);
    for (int n = 0; n < 20 && req.valid !== 1'b1; n++) @(posedge clk);
    hw <= '{1'b1, 14'h104};
    hold <= 1'b1;
    @(posedge clk);
    hw <= '0;
    rd_chk(P_PEND, 32'h10);
    chk(32'(got.size()), 32'h4);
    rd_chk(P_MISS, 32'h0);
    chk({31'h0, req.valid}, 32'h1);
    chk({29'h0, req.channel}, 32'h4);
    rd_chk(P_SEC, 32'h10);
    bus(1'b1, P_SECC, 32'h10, q);
    rd_chk(P_PEND, 32'h0);
    rd_chk(P_SEC, 32'h0);
    $display("priority and secondary test done");
    hold <= 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_chk(P_EN, 32'h0);
    rd_chk(P_PEND, 32'h0);
    rd_chk(P_MISS, 32'h0);
    rd_chk(P_SEC, 32'h0);
    rd_chk(P_MAP, 32'h0);
    chk({31'h0, req.valid}, 32'h0);
    chk(32'(irq), 32'h0);
    $display("reset test done");
    summarize();
  end
endmodule
bind quick_dma_event_latch quick_dma_event_latch_assertions sva (.core_clk_in, .resetn_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .xfer_req_out, .xfer_ack_in, .irq_out);
